// *** core/tac_addr_match.sv ***
`timescale 1ns/1ps
`include "tac_regs.svh"

module tac_addr_match
  import tac_pkg::*;
(
  // Bus address and configured base
  input  wire logic [`TAC_ADDR_W-1:0] addr_i,
  input  wire logic [`TAC_ADDR_W-1:0] base_i,
  // High for the 22-bit bus variant
  input  wire logic                   wide_i,
  // Selected register
  output tac_sel_e                    sel_o
);

  // Equal word index, and no carry out of the top
  function automatic logic word_eq(
    input logic [`TAC_IDX_W-1:0] a,
    input logic [`TAC_IDX_W:0]   b
  );
    return (b[`TAC_IDX_W] == 1'b0) && (a == b[`TAC_IDX_W-1:0]);
  endfunction

  logic [`TAC_ADDR_W-1:0] eff_addr;  // Address as the variant sees it
  logic [`TAC_ADDR_W-1:0] page_lo;   // Floor of the I/O page
  logic                   in_page;   // Address inside the I/O page
  logic [`TAC_IDX_W-1:0]  addr_idx;  // Word index, bits 1..0 dropped
  logic [`TAC_IDX_W:0]    ip_idx;    // Init/poll word index
  logic [`TAC_IDX_W:0]    sa_idx;    // Status/address word index
  logic                   hit_ip;
  logic                   hit_sa;

  // Narrow bus cannot drive bits above 17
  assign eff_addr = wide_i ? addr_i : (addr_i & `TAC_NARROW_MASK);
  // Top bits of the page are fixed ones
  assign page_lo  = wide_i ? `TAC_IOPAGE_LO : `TAC_IOPAGE18_LO;
  // Top bound taken on the word, byte offsets ignored
  assign in_page  = (eff_addr >= page_lo)
                  && ({addr_idx, {`TAC_IDX_LSB{1'b0}}} <= `TAC_IOPAGE_HI);
  // Byte offset bits never take part
  assign addr_idx = eff_addr[`TAC_ADDR_W-1:`TAC_IDX_LSB];
  assign ip_idx   = {1'b0, base_i[`TAC_ADDR_W-1:`TAC_IDX_LSB]};
  // Second register is the next word up
  assign sa_idx   = ip_idx + {{`TAC_IDX_W{1'b0}}, 1'b1};
  assign hit_ip   = in_page && word_eq(addr_idx, ip_idx);
  assign hit_sa   = in_page && word_eq(addr_idx, sa_idx);
  // Two answering words, only the first with the base at the page top; nothing else
  assign sel_o    = hit_ip ? TAC_SEL_IP
                  : (hit_sa ? TAC_SEL_SA : TAC_SEL_NONE);

endmodule // tac_addr_match

// *** core/tac_csr_decode.sv ***
// Behaviour
// - Slave answers at exactly two register addresses; the code answers at one only with the base at the page top
// - Status/address register sits one word above
// - Wide bus base anywhere in I/O page
// - Closed switch matches bit asserted, open deasserted
// - Jumper sets base bit 2: 4 or 0
// - Narrow bus compares bits 12..3 to switches
// - Narrow bus bits 17..13 fixed ones
// - Narrow bus bit 2 comes from jumper
// - Address bits 1 and 0 ignored
// - Vector written by software, held here
// - Low interrupt and DMA priority, late in chain
// - First unit default base octal 774500
`timescale 1ns/1ps
`include "tac_regs.svh"

module tac_csr_decode
  import tac_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // APB slave, carrying the host address
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [`TAC_ADDR_W-1:0]  paddr_i,
  input  wire logic [`TAC_DATA_W-1:0]  pwdata_i,
  input  wire logic [3:0]              pstrb_i,
  output logic      [`TAC_DATA_W-1:0]  prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  // Address straps from the board
  input  wire logic [`TAC_SW_W-1:0]    addr_switch_i,
  input  wire logic                    bit2_select_jumper_i,
  input  wire logic                    wide_bus_i,
  // Adapter core, same clock
  input  wire logic [`TAC_SA_W-1:0]    status_i,
  input  wire logic                    irq_pending_i,
  input  wire logic                    dma_pending_i,
  // Core strobes and held values
  output logic                         init_pulse_o,
  output logic                         poll_pulse_o,
  output logic                         sa_write_o,
  output logic      [`TAC_SA_W-1:0]    sa_data_o,
  output logic      [`TAC_VEC_W-1:0]   vector_o,
  output logic      [`TAC_ADDR_W-1:0]  base_addr_o,
  // Host priority and grant chain
  output logic                         irq_req_o,
  output logic      [1:0]              irq_level_o,
  output logic                         dma_req_o,
  output logic      [1:0]              dma_level_o,
  input  wire logic                    irq_grant_i,
  output logic                         irq_grant_o,
  input  wire logic                    dma_grant_i,
  output logic                         dma_grant_o
);

  // Reset brings up the first unit's base, so the filters
  // start at the matching strap levels
  // Default base split into its strap fields
  localparam logic [`TAC_ADDR_W-1:0] FIRST_BASE = `TAC_FIRST_BASE;
  localparam logic [`TAC_SW_W-1:0]   SW_RESET   =
    FIRST_BASE[`TAC_SW_LSB+`TAC_SW_W-1:`TAC_SW_LSB];
  localparam logic [0:0]             JMP_RESET  =
    FIRST_BASE[`TAC_JMP_BIT];
  localparam logic [0:0]             WIDE_RESET = `TAC_WIDE_RESET;
  // Zero fill above the switch field
  localparam int                     HI_PAD     =
    `TAC_ADDR_W - `TAC_SW_LSB - `TAC_SW_W;

  // Only these filtered copies feed the decode; the raw pins
  // are read by nothing else
  // Filtered strap levels
  logic [`TAC_SW_W-1:0]   sw_sync;    // Switch bank
  logic [0:0]             jmp_sync;   // Bit 2 jumper
  logic [0:0]             wide_sync;  // Bus variant

  // Base address and decode
  logic [`TAC_ADDR_W-1:0] page_base;  // Fixed-ones part of the base
  logic [`TAC_ADDR_W-1:0] base_next;  // Base built from straps
  logic [`TAC_ADDR_W-1:0] base_reg;   // Base used by the decoder
  logic                   wide_reg;   // Variant used by the decoder
  tac_sel_e               sel;        // Register hit by paddr

  // Bus phase decode
  logic                   setup_rd;   // Setup phase of a read
  logic                   access;     // Access phase, completes now
  logic                   hit;        // Address belongs to us
  logic                   wr_ip;      // Completing write to init/poll
  logic                   rd_ip;      // Completing read of init/poll
  logic                   wr_sa;      // Completing write to status/addr
  logic                   vec_load;   // Status/addr write loads vector
  logic [`TAC_DATA_W-1:0] rd_mux;     // Read value for this address

  // The registers below sit in three short processes, and each
  // resets to a constant
  // Held registers
  logic [`TAC_DATA_W-1:0] prdata_reg;
  logic [`TAC_SA_W-1:0]   sa_data_reg;
  logic [`TAC_SA_W-1:0]   sa_data_next;
  logic [`TAC_VEC_W-1:0]  vector_reg;
  logic                   init_pulse_reg;
  logic                   poll_pulse_reg;
  logic                   sa_write_reg;

  // Completing access to one register in one direction; all
  // strobes share it, so their decodes cannot drift apart
  function automatic logic targets(
    input tac_sel_e s,
    input tac_sel_e want,
    input logic     wr,
    input logic     want_wr
  );
    return (s == want) && (wr == want_wr);
  endfunction

  // Board straps come from outside, so filter them. Each bit
  // has its own three-stage chain: a one-cycle glitch or a
  // metastable first stage never reaches the base register.
  // The price is a few cycles of lag after a strap moves,
  // which only matters while the board is being set up.
  tac_sync3 #(
    .W   (`TAC_SW_W),
    .RST (SW_RESET)
  ) u_sync_sw (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (addr_switch_i),
    .q_o   (sw_sync)
  );

  tac_sync3 #(
    .W   (1),
    .RST (JMP_RESET)
  ) u_sync_jmp (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (bit2_select_jumper_i),
    .q_o   (jmp_sync)
  );

  tac_sync3 #(
    .W   (1),
    .RST (WIDE_RESET)
  ) u_sync_wide (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (wide_bus_i),
    .q_o   (wide_sync)
  );

  // The wide bus owns the whole top page, bits 21..13 set; the
  // narrow bus reaches only bits 17..0, so bits 17..13 are the
  // fixed ones there and nothing above them is decoded
  // Page floor depends on the variant
  assign page_base = wide_sync[0] ? `TAC_IOPAGE_LO : `TAC_IOPAGE18_LO;

  // Switches fill bits 12..3 with no inversion, so a closed
  // switch asks for an asserted address line and an open one
  // for a deasserted line; the jumper alone decides whether
  // the base ends in 4 or in 0
  // Closed switch (1) asks for a one; jumper gives bit 2;
  // bits 1..0 stay zero
  assign base_next = page_base
                   | {{HI_PAD{1'b0}}, sw_sync, jmp_sync, 2'b00};

  // Limitation: a strap moved during a long run of back-to-back
  // transfers waits for the first idle cycle before it counts
  // Base is registered so a strap change never splits a transfer
  // across two decodes; it lags the pins by a few cycles
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_reg <= FIRST_BASE;
      wide_reg <= WIDE_RESET[0];
    end else if (!psel_i) begin
      base_reg <= base_next;
      wide_reg <= wide_sync[0];
    end
  end

  // Address comparator: pure logic on paddr and the held base,
  // so the target is known in the setup cycle already
  tac_addr_match u_match (
    .addr_i (paddr_i),
    .base_i (base_reg),
    .wide_i (wide_reg),
    .sel_o  (sel)
  );

  // Phase and target strobes
  assign setup_rd = psel_i && !penable_i && !pwrite_i;
  assign access   = psel_i && penable_i;
  assign hit      = (sel != TAC_SEL_NONE);
  assign wr_ip    = access && targets(sel, TAC_SEL_IP, pwrite_i, 1'b1);
  assign rd_ip    = access && targets(sel, TAC_SEL_IP, pwrite_i, 1'b0);
  assign wr_sa    = access && targets(sel, TAC_SEL_SA, pwrite_i, 1'b1);
  // Vector taken only with both low lanes and the step bit
  assign vec_load = wr_sa && pstrb_i[0] && pstrb_i[1]
                  && pwdata_i[`TAC_SA_STEP_BIT];

  // APB cannot leave a transfer open, so a foreign address is
  // still completed at once; the error flag and the missing
  // side effects are how this block declines to claim it,
  // and the master is never left hanging on a wrong address
  // Zero wait states: the slave is always ready in access
  assign pready_o  = access;
  // Foreign address: no data, error flag instead of a claim
  assign pslverr_o = access && !hit;

  // Read selection. The value is taken into prdata at the end of
  // setup, so it stands unchanged for the whole access cycle even
  // if the core status moves underneath
  always_comb begin
    case (sel)
      // Init/poll reads back the decoder's own base
      TAC_SEL_IP: rd_mux = {{(`TAC_DATA_W-`TAC_ADDR_W){1'b0}},
                            base_reg};
      // Status/address reads the core status word
      TAC_SEL_SA: rd_mux = {{(`TAC_DATA_W-`TAC_SA_W){1'b0}},
                            status_i};
      // Not ours: reads as zero
      default:    rd_mux = '0;
    endcase
  end

  // Only lanes 0 and 1 exist; strobes for lanes 2 and 3 are
  // accepted and ignored
  // Byte lanes of the status/address write word
  genvar l;
  generate
    for (l = 0; l < `TAC_SA_W/8; l++) begin : g_lane
      assign sa_data_next[8*l +: 8] = (wr_sa && pstrb_i[l])
                                    ? pwdata_i[8*l +: 8]
                                    : sa_data_reg[8*l +: 8];
    end
  endgenerate

  // Held until the next read setup, so a write in between does
  // not disturb what the last read returned
  // Read data is captured in setup, stable through access
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_reg <= '0;
    end else if (setup_rd) begin
      prdata_reg <= rd_mux;
    end
  end

  // The vector has no strap: software writes it through the
  // status/address register and it is kept here until the next such write or reset.
  // Both low lanes are needed, so half a word never loads it
  // and a byte write of the status word leaves it alone
  // Written word and software vector
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sa_data_reg <= '0;
      vector_reg  <= '0;
    end else begin
      sa_data_reg <= sa_data_next;
      if (vec_load) begin
        vector_reg <= pwdata_i[`TAC_VEC_W-1:0];
      end
    end
  end

  // Registered so the core sees clean pulses a cycle late,
  // instead of a glitchy decode of the live bus; back-to-back
  // transfers still give separate pulses, as setup lies between
  // One-cycle strobes to the core, after the completing edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      init_pulse_reg <= 1'b0;
      poll_pulse_reg <= 1'b0;
      sa_write_reg   <= 1'b0;
    end else begin
      init_pulse_reg <= wr_ip;
      poll_pulse_reg <= rd_ip;
      sa_write_reg   <= wr_sa;
    end
  end

  // Trade-off: the grant passes through in zero cycles so the
  // chain stays fast; this block sits late in it, so little
  // waits behind it
  // Requests carry the lowest priority; a grant not wanted
  // here travels on down the chain
  assign irq_req_o   = irq_pending_i;
  assign irq_level_o = `TAC_IRQ_LEVEL;
  assign dma_req_o   = dma_pending_i;
  assign dma_level_o = `TAC_DMA_LEVEL;
  assign irq_grant_o = irq_grant_i && !irq_pending_i;
  assign dma_grant_o = dma_grant_i && !dma_pending_i;

  // Every data output comes straight from a flip-flop
  // Register-driven outputs
  assign prdata_o     = prdata_reg;
  assign sa_data_o    = sa_data_reg;
  assign vector_o     = vector_reg;
  assign base_addr_o  = base_reg;
  assign init_pulse_o = init_pulse_reg;
  assign poll_pulse_o = poll_pulse_reg;
  assign sa_write_o   = sa_write_reg;

endmodule // tac_csr_decode

// *** core/tac_sync3.sv ***
`timescale 1ns/1ps
`include "tac_regs.svh"

module tac_sync3 #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Raw level from a pin
  input  wire logic [W-1:0] d_i,
  // Filtered level
  output logic      [W-1:0] q_o
);

  genvar b;

  // One three-stage chain per bit
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic s1_reg;  // First stage, read only by s2
      logic s2_reg;  // Second stage
      logic s3_reg;  // Third stage
      logic q_reg;   // Accepted level

      // Change is taken only once stages two and three agree
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_reg <= RST[b];
          s2_reg <= RST[b];
          s3_reg <= RST[b];
          q_reg  <= RST[b];
        end else begin
          s1_reg <= d_i[b];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
          end
        end
      end

      assign q_o[b] = q_reg;
    end
  endgenerate

endmodule // tac_sync3

// *** shared/tac_pkg.sv ***
package tac_pkg;

  // Which adapter register a bus address selects
  typedef enum logic [1:0] {
    TAC_SEL_NONE,
    TAC_SEL_IP,
    TAC_SEL_SA
  } tac_sel_e;

endpackage

// *** shared/tac_regs.svh ***
`ifndef TAC_REGS_SVH
`define TAC_REGS_SVH

// Host address width carried on paddr
`define TAC_ADDR_W       22
// Word index width (address bits 21..2)
`define TAC_IDX_W        20
// Lowest compared address bit
`define TAC_IDX_LSB      2
// Switch bank: ten bits at address bits 12..3
`define TAC_SW_LSB       3
`define TAC_SW_W         10
// Jumper drives base bit 2
`define TAC_JMP_BIT      2
// I/O page bounds, wide bus (octal 17760000..17777774)
`define TAC_IOPAGE_LO    22'h3fe000
`define TAC_IOPAGE_HI    22'h3ffffc
// I/O page floor, narrow bus (bits 17..13 all ones)
`define TAC_IOPAGE18_LO  22'h03e000
// Narrow bus sees only address bits 17..0
`define TAC_NARROW_MASK  22'h03ffff
// First tape unit base, narrow bus (octal 774500)
`define TAC_FIRST_BASE   22'h03f940
// Reset value of the bus width strap (narrow)
`define TAC_WIDE_RESET   1'b0
// Register widths
`define TAC_SA_W         16
`define TAC_VEC_W        8
`define TAC_DATA_W       32
// Status/address write bit that also loads the vector
`define TAC_SA_STEP_BIT  15
// Request priorities: lowest level on both
`define TAC_IRQ_LEVEL    2'h0
`define TAC_DMA_LEVEL    2'h0

`endif

// *** test/tac_apb_host.sv ***
`timescale 1ns/1ps
`include "tac_regs.svh"

module tac_apb_host (
  // Clock and slave answer
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  // Request lines
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [21:0]      paddr_o,
  output logic [31:0]      pwdata_o,
  output logic [3:0]       pstrb_o
);
  // Idle bus from time zero
  initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} = '0;

  // One transfer; request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [21:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err,
                      output bit tmo);
    int n;
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= a;
    pwdata_o  <= d;
    pstrb_o   <= s;
    @(posedge clk_i);
    penable_o <= 1'b1;
    tmo = 1'b1;
    // Bounded wait, the slave may stall
    for (n = 0; n < 16 && tmo; n++) begin
      @(posedge clk_i);
      tmo = (pready_i !== 1'b1);
    end
    rd  = prdata_i;
    err = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    // Released address and data lines never keep the stale value
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask
endmodule // tac_apb_host

// *** test/tac_csr_decode_properties.sv ***
`timescale 1ns/1ps
`include "tac_regs.svh"

module tac_csr_decode_properties (
  // Clock, reset and bus
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [`TAC_ADDR_W-1:0] paddr_i,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o,
  // Core strobes and held values
  input wire logic                   init_pulse_o,
  input wire logic                   poll_pulse_o,
  input wire logic                   sa_write_o,
  input wire logic [`TAC_VEC_W-1:0]  vector_o,
  input wire logic [`TAC_ADDR_W-1:0] base_addr_o,
  // Grant chain
  input wire logic                   irq_pending_i,
  input wire logic                   irq_grant_i,
  input wire logic                   irq_grant_o,
  input wire logic [1:0]             irq_level_o,
  input wire logic [1:0]             dma_level_o
);
  // Narrow base has bit 21 clear, so it also tells the mode
  wire logic [21:0] addr_m = base_addr_o[21] ? paddr_i
                             : (paddr_i & `TAC_NARROW_MASK);
  wire logic        access = psel_i && penable_i;
  wire logic        ip_hit = addr_m[21:2] == base_addr_o[21:2];
  // Carry kept, so a base at the page top has no second word
  wire logic        sa_hit = {1'b0, addr_m[21:2]}
                             == ({1'b0, base_addr_o[21:2]} + 21'd1);

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Completed accesses by kind
  sequence s_ip_wr; access && pwrite_i && ip_hit; endsequence
  sequence s_ip_rd; access && !pwrite_i && ip_hit; endsequence
  sequence s_sa_wr; access && pwrite_i && sa_hit; endsequence

  a_zero_wait: assert property (access |-> pready_o)
    else $error("access not answered at once");
  a_ip_write_pulse: assert property (s_ip_wr |=> init_pulse_o ##1 !init_pulse_o)
    else $error("init strobe wrong");
  a_ip_read_pulse: assert property (s_ip_rd |=> poll_pulse_o ##1 !poll_pulse_o)
    else $error("poll strobe wrong");
  a_sa_write_pulse: assert property (s_sa_wr |=> sa_write_o)
    else $error("status word strobe missing");
  a_hit_no_error: assert property (access && (ip_hit || sa_hit) |-> !pslverr_o)
    else $error("own address refused");
  a_miss_error: assert property (access && !ip_hit && !sa_hit |-> pslverr_o)
    else $error("foreign address claimed");
  a_no_stray_strobe: assert property ((init_pulse_o || sa_write_o)
    |-> $past(access && pwrite_i && (ip_hit || sa_hit)))
    else $error("strobe without own write");
  a_vector_held: assert property ($changed(vector_o)
    |-> $past(access && pwrite_i && sa_hit))
    else $error("vector moved without write");
  a_base_in_page: assert property (base_addr_o[17:13] == 5'h1f
    && base_addr_o[1:0] == 2'b00)
    else $error("base outside page");
  a_grant_chain: assert property (irq_grant_o
    == (irq_grant_i && !irq_pending_i))
    else $error("grant chain wrong");
  a_low_level: assert property (irq_level_o == 2'h0 && dma_level_o == 2'h0)
    else $error("priority not lowest");
endmodule // tac_csr_decode_properties

bind tac_csr_decode tac_csr_decode_properties chk_u (.clk_i, .rst_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .pslverr_o,
  .init_pulse_o, .poll_pulse_o, .sa_write_o, .vector_o, .base_addr_o,
  .irq_pending_i, .irq_grant_i, .irq_grant_o, .irq_level_o, .dma_level_o);

// *** test/tac_csr_decode_tb_top.sv ***
`timescale 1ns/1ps
`include "tac_regs.svh"

module tac_csr_decode_tb_top;
  // Design ports
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i;
  logic        pready_o, pslverr_o, bit2_select_jumper_i, wide_bus_i;
  logic        irq_pending_i, dma_pending_i, irq_grant_i, dma_grant_i;
  logic        init_pulse_o, poll_pulse_o, sa_write_o, irq_req_o;
  logic        dma_req_o, irq_grant_o, dma_grant_o;
  logic [21:0] paddr_i, base_addr_o;
  logic [31:0] pwdata_i, prdata_o;
  logic [3:0]  pstrb_i;
  logic [9:0]  addr_switch_i;
  logic [15:0] status_i, sa_data_o;
  logic [7:0]  vector_o;
  logic [1:0]  irq_level_o, dma_level_o;
  // Bench state
  int          n_fail, check_count, i;
  logic [31:0] rd, d, d2;
  logic        err, j, w, top;
  bit          tmo;
  logic [21:0] b, hi;
  logic [9:0]  sw;
  logic [3:0]  st;

  tac_csr_decode dut_u (.*);
  tac_apb_host host_u (.clk_i, .pready_i(pready_o), .pslverr_i(pslverr_o),
    .prdata_i(prdata_o), .psel_o(psel_i), .penable_o(penable_i),
    .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i),
    .pstrb_o(pstrb_i));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic test_done();
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Transfer, a hang ends the run
  task automatic bus(input logic wr, input logic [21:0] a,
                     input logic [31:0] dd, input logic [3:0] s);
    host_u.xfer(wr, a, dd, s, rd, err, tmo);
    if (tmo) begin
      n_fail++;
      test_done();
    end
  endtask

  // Base that a strap setting must give
  function automatic logic [21:0] exp_base(logic [9:0] s, logic jj, logic ww);
    return ww ? {9'h1ff, s, jj, 2'b00} : {4'h0, 5'h1f, s, jj, 2'b00};
  endfunction

  initial begin
    {n_fail, check_count} = '0;
    {rst_i, addr_switch_i, status_i} = {1'b1, 10'h328, 16'h0000};
    {bit2_select_jumper_i, wide_bus_i, irq_pending_i} = '0;
    {dma_pending_i, irq_grant_i, dma_grant_i} = '0;
    void'($urandom(32'h7a2723ec));
    repeat (8) @(posedge clk_i);
    check(base_addr_o, 22'h03f940);
    rst_i <= 1'b0;
    bus(1'b0, 22'h03f940, 32'h0, 4'h0);
    check(rd, 32'h0003f940);
    for (i = 0; i < 24; i++) begin
      {sw, j, w} = {$urandom} % 4096;
      // Page floor and page top first
      if (i < 2) {sw, j, w} = {{10{i[0]}}, i[0], 1'b1};
      @(posedge clk_i);
      {addr_switch_i, bit2_select_jumper_i, wide_bus_i} <= {sw, j, w};
      status_i <= $urandom;
      // Straps pass the filter, then load the base
      repeat (7) @(posedge clk_i);
      b = exp_base(sw, j, w);
      top = &b[17:2];
      hi = w ? 22'h0 : ($urandom & 22'h3c0000);
      check(base_addr_o, b);
      bus(1'b1, (b | hi) + 22'($urandom % 4), $urandom, 4'hf);
      check(err, 1'b0);
      bus(1'b0, (b | hi) + 22'd4 + 22'($urandom % 4), 32'h0, 4'h0);
      check(rd, top ? 32'h0 : {16'h0, status_i});
      check(err, top);
      d = $urandom | 32'h00008000;
      bus(1'b1, b + 22'd4, d, 4'h3);
      // Random lanes; step bit set only when a low lane is missing
      st = 4'($urandom);
      d2 = $urandom;
      if (st[1:0] == 2'b11) d2[15] = 1'b0;
      bus(1'b1, b + 22'd4, d2, st);
      @(negedge clk_i);
      if (!top) check(vector_o, d[7:0]);
      if (!top) check(sa_data_o, {st[1] ? d2[15:8] : d[15:8],
                                  st[0] ? d2[7:0] : d[7:0]});
      bus(1'b0, b + 22'd8, 32'h0, 4'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      bus(1'b0, b - 22'd4, 32'h0, 4'h0);
      check(err, 1'b1);
      @(posedge clk_i);
      {irq_pending_i, dma_pending_i, irq_grant_i, dma_grant_i} <= $urandom;
      @(negedge clk_i);
      check({irq_req_o, irq_grant_o, dma_req_o, dma_grant_o},
            {irq_pending_i, irq_grant_i & !irq_pending_i, dma_pending_i,
             dma_grant_i & !dma_pending_i});
    end
    test_done();
  end
endmodule // tac_csr_decode_tb_top
